// File: rtl/ptd_defs.vh
// constants for the transmit descriptor phase block
`ifndef PTD_DEFS_VH
`define PTD_DEFS_VH
`define PTD_DESC_W      128
`define PTD_DATA_W      64
`define PTD_GRP_HI      127
`define PTD_HAS_DATA    126
`define PTD_FMT_HI      126
`define PTD_FMT_LO      125
`define PTD_TYPE_HI     124
`define PTD_TYPE_LO     120
`define PTD_LEN_HI      105
`define PTD_LEN_LO      96
`define PTD_ADDR2_4DW   2
`define PTD_ADDR2_3DW   34
`define PTD_FMT_4DW     125
`define PTD_LEN_W       10
`define PTD_NUM_VC      2
`endif

// File: rtl/ptd_tx_desc.v
// transmit descriptor phase logic, one lane of signals per virtual channel
`timescale 1ns/1ns
`include "ptd_defs.vh"

module ptd_tx_desc #(
  parameter NUM_VC = `PTD_NUM_VC
) (
  input  wire                          clk,
  input  wire                          rst_n,
  input  wire [NUM_VC-1:0]             xmit_req,
  input  wire [NUM_VC*`PTD_DESC_W-1:0] xmit_desc,
  input  wire [NUM_VC-1:0]             xmit_frame,
  input  wire [NUM_VC-1:0]             xmit_payload_valid,
  input  wire [NUM_VC*`PTD_DATA_W-1:0] xmit_data,
  input  wire [NUM_VC-1:0]             link_ready,
  output reg  [NUM_VC-1:0]             xmit_ack,
  output reg  [NUM_VC-1:0]             xmit_wait_state,
  output reg  [NUM_VC-1:0]             desc_valid,
  output reg  [NUM_VC*`PTD_DESC_W-1:0] desc_out,
  output reg  [NUM_VC-1:0]             desc_has_data,
  output reg  [NUM_VC*`PTD_LEN_W-1:0]  desc_len,
  output reg  [NUM_VC-1:0]             data_valid,
  output reg  [NUM_VC*32-1:0]          data_dword,
  output reg  [NUM_VC-1:0]             data_last
);

  ////////////////////////////////////////////////////////////////////////
  // header field helpers

  // address bit 2 location depends on header size
  function addr_bit2;
    input [`PTD_DESC_W-1:0] d;
    begin
      if (d[`PTD_FMT_4DW])
        addr_bit2 = d[`PTD_ADDR2_4DW];
      else
        addr_bit2 = d[`PTD_ADDR2_3DW];
    end
  endfunction

  // header carries a fourth doubleword
  function hdr_is_4dw;
    input [`PTD_DESC_W-1:0] d;
    begin
      hdr_is_4dw = d[`PTD_FMT_4DW];
    end
  endfunction

  // payload flag of a header
  function hdr_has_data;
    input [`PTD_DESC_W-1:0] d;
    begin
      hdr_has_data = d[`PTD_HAS_DATA];
    end
  endfunction

  // length field in doublewords
  function [`PTD_LEN_W-1:0] hdr_len;
    input [`PTD_DESC_W-1:0] d;
    begin
      hdr_len = d[`PTD_LEN_HI:`PTD_LEN_LO];
    end
  endfunction

  // one dword left to move
  function last_dword;
    input [`PTD_LEN_W-1:0] n;
    begin
      last_dword = (n == 10'h001);
    end
  endfunction

  // one dword fewer left
  function [`PTD_LEN_W-1:0] count_down;
    input [`PTD_LEN_W-1:0] n;
    begin
      count_down = n - 10'h001;
    end
  endfunction

  // pick the low or high dword of a data word
  function [31:0] lane_word;
    input [`PTD_DATA_W-1:0] w;
    input                   hi;
    begin
      if (hi)
        lane_word = w[63:32];
      else
        lane_word = w[31:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // per-channel descriptor and data phase engines

  localparam ST_IDLE = 3'h1;
  localparam ST_ACK  = 3'h2;
  localparam ST_DATA = 3'h4;

  // dword width of the forwarded payload lane
  localparam DW_W = 32;

  genvar v;
  generate
    for (v = 0; v < NUM_VC; v = v + 1)
    begin : g_vc
      // this channel's slices of the shared buses
      wire [`PTD_DESC_W-1:0] req_desc = xmit_desc[v*`PTD_DESC_W +: `PTD_DESC_W];
      wire [`PTD_DATA_W-1:0] in_data  = xmit_data[v*`PTD_DATA_W +: `PTD_DATA_W];

      // descriptor and data phase state
      reg  [2:0]             state_ff;
      reg  [2:0]             nxt_state;

      // link ready synchroniser stages
      reg                    rdy_s1_ff;
      reg                    rdy_ff;

      // lane select and dwords still to move
      reg                    hi_ff;       // next dword lane select
      reg                    nxt_hi;
      reg  [`PTD_LEN_W-1:0]  left_ff;     // dwords still to move
      reg  [`PTD_LEN_W-1:0]  nxt_left;

      // per-cycle decode results
      reg                    take;        // descriptor accepted this cycle
      reg                    beat;        // data phase accepted this cycle
      reg                    data_ok;     // a data beat may be taken now

      ////////////////////////////////////////////////////////////////////
      // link-ready comes from outside, sync it
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          rdy_s1_ff <= 1'b0;
          rdy_ff    <= 1'b0;
        end
        else
        begin
          rdy_s1_ff <= link_ready[v];
          rdy_ff    <= rdy_s1_ff;
        end
      end

      ////////////////////////////////////////////////////////////////////
      // acceptance decode
      always @*
      begin
        // a held request counts again right after an ack for a header without payload
        take    = xmit_req[v] && rdy_ff && (state_ff == ST_IDLE);
        // data may share the accept cycle only for a 3-dword header
        data_ok = (state_ff == ST_DATA) ||
                  (take && !hdr_is_4dw(req_desc));
        // payload taken only while the link is ready
        beat    = data_ok && xmit_payload_valid[v] && rdy_ff;
      end

      ////////////////////////////////////////////////////////////////////
      // next state
      always @*
      begin
        nxt_state = state_ff;
        case (state_ff)
          ST_IDLE:
          begin
            if (take)
              nxt_state = ST_ACK;
          end
          ST_ACK:
          begin
            // payload only when bit 126 set
            if (desc_has_data[v])
              nxt_state = ST_DATA;
            else
              nxt_state = ST_IDLE;
          end
          ST_DATA:
          begin
            if (beat && last_dword(left_ff))
              nxt_state = ST_IDLE;
          end
          default:
            nxt_state = ST_IDLE;
        endcase
      end

      ////////////////////////////////////////////////////////////////////
      // lane select and remaining dword count
      always @*
      begin
        nxt_hi   = hi_ff;
        nxt_left = left_ff;
        if (take)
        begin
          // first dword lane from address bit 2
          nxt_hi   = addr_bit2(req_desc);
          nxt_left = hdr_len(req_desc);
        end
        else if (beat && state_ff == ST_DATA)
        begin
          // lanes alternate beat by beat
          nxt_hi   = ~hi_ff;
          nxt_left = count_down(left_ff);
        end
      end

      ////////////////////////////////////////////////////////////////////
      // control state, lane and remaining count
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          state_ff <= ST_IDLE;
          hi_ff    <= 1'b0;
          left_ff  <= 10'h000;
        end
        else
        begin
          // well-formed input assumed, nothing is checked here
          state_ff <= nxt_state;
          hi_ff    <= nxt_hi;
          left_ff  <= nxt_left;
        end
      end

      ////////////////////////////////////////////////////////////////////
      // acknowledge pulse, wait state and descriptor strobe
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          xmit_ack[v]        <= 1'b0;
          xmit_wait_state[v] <= 1'b1;
          desc_valid[v]      <= 1'b0;
        end
        else
        begin
          // one accept gives one single-cycle pulse
          xmit_ack[v]        <= take;
          // throttle while the synchronised ready is low
          xmit_wait_state[v] <= ~rdy_ff;
          desc_valid[v]      <= take;
        end
      end

      ////////////////////////////////////////////////////////////////////
      // captured header and the fields read from it
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          desc_out[v*`PTD_DESC_W +: `PTD_DESC_W] <= 128'h0;
          desc_has_data[v]                       <= 1'b0;
          desc_len[v*`PTD_LEN_W +: `PTD_LEN_W]   <= 10'h000;
        end
        else if (take)
        begin
          // header bytes kept in bus order, byte 0 at top
          desc_out[v*`PTD_DESC_W +: `PTD_DESC_W] <= req_desc;
          desc_has_data[v]                       <= hdr_has_data(req_desc);
          desc_len[v*`PTD_LEN_W +: `PTD_LEN_W]   <= hdr_len(req_desc);
        end
      end

      ////////////////////////////////////////////////////////////////////
      // forwarded payload dwords
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          data_valid[v]              <= 1'b0;
          data_dword[v*DW_W +: DW_W] <= 32'h0;
          data_last[v]               <= 1'b0;
        end
        else
        begin
          // only beats in the data state are forwarded
          data_valid[v]              <= beat && (state_ff == ST_DATA);
          // dword lane follows the running address bit 2
          data_dword[v*DW_W +: DW_W] <= lane_word(in_data, hi_ff);
          data_last[v]               <= beat && (state_ff == ST_DATA) && last_dword(left_ff);
        end
      end
    end
  endgenerate

endmodule

// File: test/ptd_tx_desc_properties.sv
// assertions on channel 0 of the transmit descriptor block
`timescale 1ns/1ns
`include "ptd_defs.vh"
module ptd_tx_desc_checker #(
  parameter NUM_VC = 2
) (
  input wire                          clk,
  input wire                          rst_n,
  input wire [NUM_VC-1:0]             xmit_req,
  input wire [NUM_VC*`PTD_DESC_W-1:0] xmit_desc,
  input wire [NUM_VC-1:0]             link_ready,
  input wire [NUM_VC-1:0]             xmit_ack,
  input wire [NUM_VC-1:0]             xmit_wait_state,
  input wire [NUM_VC-1:0]             desc_valid,
  input wire [NUM_VC*`PTD_DESC_W-1:0] desc_out,
  input wire [NUM_VC-1:0]             desc_has_data,
  input wire [NUM_VC*`PTD_LEN_W-1:0]  desc_len
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_ack_pulse: assert property (xmit_ack[0] |=> !xmit_ack[0])
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (xmit_ack[0] |-> $past(xmit_req[0]))
    else $error("ack without request");
  a_ack_valid: assert property (xmit_ack[0] |-> desc_valid[0])
    else $error("ack without captured descriptor");
  a_desc_bytes: assert property (xmit_ack[0] |-> desc_out[127:0] == $past(xmit_desc[127:0]))
    else $error("captured header differs");
  a_data_flag: assert property (desc_valid[0] |-> desc_has_data[0] == desc_out[126])
    else $error("payload flag wrong");
  a_len_field: assert property (desc_valid[0] |-> desc_len[9:0] == desc_out[105:96])
    else $error("length field wrong");
  a_wait_shown: assert property (!link_ready[0] [*3] |=> xmit_wait_state[0])
    else $error("no wait state while not ready");
  a_back_to_back: assert property (xmit_ack[0] && !desc_has_data[0] ##1 xmit_req[0]
    && link_ready[0] |-> ##[1:4] xmit_ack[0])
    else $error("held request not taken again");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |-> !xmit_ack[0]
    && xmit_wait_state[0])
    else $error("ack during reset");
endmodule
bind ptd_tx_desc ptd_tx_desc_checker #(.NUM_VC(NUM_VC)) i_chk (.clk(clk), .rst_n(rst_n),
  .xmit_req(xmit_req), .xmit_desc(xmit_desc), .link_ready(link_ready), .xmit_ack(xmit_ack),
  .xmit_wait_state(xmit_wait_state), .desc_valid(desc_valid), .desc_out(desc_out),
  .desc_has_data(desc_has_data), .desc_len(desc_len));

// File: test/ptd_app_model.sv
// application side model driving one channel
`timescale 1ns/1ns
module ptd_app_model (
  input  wire          clk,
  input  wire          xmit_ack,
  output logic         xmit_req = 0,
  output logic [127:0] xmit_desc = 0,
  output logic         xmit_frame = 0,
  output logic         xmit_payload_valid = 0,
  output logic [63:0]  xmit_data = 0
);
  // request and header held until ack, then payload beats
  task send(input [127:0] d, input integer beats, input bit rel);
    integer i;
    begin
      xmit_req <= 1'b1;
      xmit_desc <= d;
      xmit_frame <= beats > 0;
      @(posedge clk);
      while (xmit_ack !== 1'b1) @(posedge clk);
      if (rel)
      begin
        xmit_req <= 1'b0;
        xmit_desc <= ~d;
      end
      for (i = 0; i < beats; i++)
      begin
        xmit_payload_valid <= 1'b1;
        xmit_frame <= i < beats - 1;
        xmit_data <= {32'hA0000000 + i, 32'hB0000000 + i};
        @(posedge clk);
      end
      xmit_payload_valid <= 1'b0;
      xmit_data <= ~xmit_data;
      // let the release settle before any next request
      if (rel)
        @(posedge clk);
    end
  endtask
endmodule

// File: test/ptd_tx_desc_bench.sv
// bench for the transmit descriptor block
`timescale 1ns/1ns
module ptd_tx_desc_bench;
  logic         clk = 0, rst_n = 1, rdy = 1;
  integer       err_total = 0, samples_checked = 0, cyc = 0, n;
  wire [1:0]    req, ack, frm, pv, wst, dv, hd, dval, last;
  wire [255:0]  desc, dout;
  wire [127:0]  data;
  wire [63:0]   dw;
  wire [19:0]   len;
  localparam [127:0] D0 = 128'h00000001_0000000F_00000010_00000000;
  localparam [127:0] D2 = 128'h20000001_0000000F_00000000_00000040;
  localparam [127:0] D3 = 128'h40000002_0000000F_00000004_00000000;
  ptd_tx_desc #(.NUM_VC(2)) i_ptd_tx_desc (.clk(clk), .rst_n(rst_n), .xmit_req(req),
    .xmit_desc(desc), .xmit_frame(frm), .xmit_payload_valid(pv), .xmit_data(data),
    .link_ready({rdy, rdy}), .xmit_ack(ack), .xmit_wait_state(wst), .desc_valid(dv),
    .desc_out(dout), .desc_has_data(hd), .desc_len(len), .data_valid(dval),
    .data_dword(dw), .data_last(last));
  ptd_app_model i_ptd_app_model0 (.clk(clk), .xmit_ack(ack[0]), .xmit_req(req[0]),
    .xmit_desc(desc[127:0]), .xmit_frame(frm[0]), .xmit_payload_valid(pv[0]),
    .xmit_data(data[63:0]));
  ptd_app_model i_ptd_app_model1 (.clk(clk), .xmit_ack(ack[1]), .xmit_req(req[1]),
    .xmit_desc(desc[255:128]), .xmit_frame(frm[1]), .xmit_payload_valid(pv[1]),
    .xmit_data(data[127:64]));
  initial forever #50 clk = ~clk;
  task chk(input string nm, input [127:0] e, input [127:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task conclude;
    $display("mismatches %0d comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      conclude;
    end
  end
  task t_plain;
    i_ptd_app_model0.send(D0, 0, 0);
    chk("desc", D0, dout[127:0]);
    chk("len", 1, len[9:0]);
    chk("has_data", 0, hd[0]);
    i_ptd_app_model0.send(D2, 0, 1);
    chk("b2b desc", D2, dout[127:0]);
    i_ptd_app_model1.send(D0, 0, 1);
    chk("ch1 desc", D0, dout[255:128]);
  endtask
  task t_data;
    fork
      i_ptd_app_model0.send(D3, 2, 1);
      begin
        for (n = 0; n < 20 && dval[0] !== 1'b1; n++) @(posedge clk);
        chk("first dword", 32'hA0000000, dw[31:0]);
        chk("has_data", 1, hd[0]);
        @(posedge clk);
        chk("second dword", 32'hB0000001, dw[31:0]);
        chk("last", 1, last[0]);
      end
    join
  endtask
  task t_wait;
    rdy <= 1'b0;
    repeat (5) @(posedge clk);
    chk("wait", 1, wst[0]);
    fork
      i_ptd_app_model0.send(D2, 0, 1);
      begin
        repeat (3) @(posedge clk);
        chk("held ack", 0, ack[0]);
        rdy <= 1'b1;
      end
    join
    chk("late desc", D2, dout[127:0]);
    chk("wait low", 0, wst[0]);
  endtask
  initial
  begin
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    chk("reset out", 2'h0, {ack[0], ~wst[0]});
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_plain;
    t_data;
    t_wait;
    conclude;
  end
endmodule
